// ==== hw/drc_pkg.sv ====
// Constants for the descriptor reserved-field checker
package drc_pkg;
    // Descriptor layout
    localparam int DESC_W     = 512;
    localparam int PRIV_BIT   = 31;
    localparam int FLAGS_LO   = 32;
    localparam int FLAGS_W    = 24;
    localparam int OPC_LO     = 56;
    localparam int CRA_LO     = 8;
    localparam int CRA_HI     = 15;
    localparam int IH_LO      = 36;
    localparam int IH_HI      = 37;
    // Flag bit positions
    localparam int F_FENCE    = 0;
    localparam int F_BOF      = 1;
    localparam int F_CRAV     = 2;
    localparam int F_RCR      = 3;
    localparam int F_RCI      = 4;
    localparam int F_CRST     = 5;
    localparam int F_RSV6     = 6;
    localparam int F_CHKRES   = 7;
    localparam int F_CC       = 8;
    localparam int F_A1TC     = 9;
    localparam int F_A2TC     = 10;
    localparam int F_A3TC     = 11;
    localparam int F_CRTC     = 12;
    localparam int F_SO       = 13;
    localparam int F_DRB      = 14;
    localparam int F_DSTST    = 15;
    localparam int F_RB1V     = 16;
    localparam int F_RB2V     = 17;
    localparam logic [23:0] OPSPEC_M = 24'hff0000;
    localparam logic [23:0] TABLED_M = 24'h00ef83;
    localparam logic [23:0] DRAIN_OPSPEC = 24'h030000;
    // Operation codes
    localparam logic [7:0] OP_NOOP  = 8'h00;
    localparam logic [7:0] OP_BATCH = 8'h01;
    localparam logic [7:0] OP_DRAIN = 8'h02;
    localparam logic [7:0] OP_MOVE  = 8'h03;
    localparam logic [7:0] OP_FILL  = 8'h04;
    localparam logic [7:0] OP_CMP   = 8'h05;
    localparam logic [7:0] OP_CMPP  = 8'h06;
    localparam logic [7:0] OP_CRDEL = 8'h07;
    localparam logic [7:0] OP_APDEL = 8'h08;
    localparam logic [7:0] OP_DUAL  = 8'h09;
    localparam logic [7:0] OP_CRC   = 8'h10;
    localparam logic [7:0] OP_CPCRC = 8'h11;
    localparam logic [7:0] OP_DIFC  = 8'h12;
    localparam logic [7:0] OP_DIFI  = 8'h13;
    localparam logic [7:0] OP_DIFS  = 8'h14;
    localparam logic [7:0] OP_DIFU  = 8'h15;
    localparam logic [7:0] OP_FLUSH = 8'h20;
    // Allowed tabled flags per operation
    localparam logic [23:0] AL_NOOP  = 24'h000001;
    localparam logic [23:0] AL_DRAIN = 24'h000600;
    localparam logic [23:0] AL_MOVE  = 24'h00e703;
    localparam logic [23:0] AL_FILL  = 24'h00e503;
    localparam logic [23:0] AL_CMP   = 24'h000683;
    localparam logic [23:0] AL_CMPP  = 24'h000283;
    localparam logic [23:0] AL_CRDEL = 24'h00ef83;
    localparam logic [23:0] AL_DUAL  = 24'h00ef03;
    localparam logic [23:0] AL_CRC   = 24'h000a03;
    localparam logic [23:0] AL_DIFC  = 24'h000203;
    localparam logic [23:0] AL_BATCH = 24'h000200;
    // Reserved byte masks, bit n is byte n
    localparam logic [63:0] RB_NOOP  = 64'hffffffcfffff0000;
    localparam logic [63:0] RB_DRAIN = 64'hffffffcf00000000;
    localparam logic [63:0] RB_MOVE  = 64'hffffffc000000000;
    localparam logic [63:0] RB_CMP   = 64'hfffffec000000000;
    localparam logic [63:0] RB_CRDEL = 64'hfef000c000000000;
    localparam logic [63:0] RB_APDEL = 64'hfffff0c000000000;
    localparam logic [63:0] RB_DUAL  = 64'hffff00c000000000;
    localparam logic [63:0] RB_CRC   = 64'hfffff0c0ff000000;
    localparam logic [63:0] RB_DIFC  = 64'hff00fac0ff000000;
    localparam logic [63:0] RB_DIFI  = 64'h00fff9c000000000;
    localparam logic [63:0] RB_DIFS  = 64'hff00fac000000000;
    localparam logic [63:0] RB_DIFU  = 64'h0000f8c000000000;
    localparam logic [63:0] RB_FLUSH = 64'hffffffc000ff0000;
    localparam logic [63:0] RB_BATCH = 64'hffffffc0ff000000;
endpackage : drc_pkg

// ==== hw/drc_op_table.sv ====
// Per-operation allowed flag and reserved byte lookup
`timescale 1ns/100ps
module drc_op_table
    import drc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Lookup
    input  wire logic [7:0]  op,
    output logic      [23:0] allow_q,
    output logic      [63:0] resv_q,
    output logic             known_q,
    output logic             wrmem_q,
    output logic             flush_q,
    output logic             drain_q,
    output logic             needcr_q
);
    logic [23:0] allow_d;
    logic [63:0] resv_d;
    logic        known_d;
    logic        wrmem_d;

    always_comb begin
        known_d = 1'b1;
        wrmem_d = 1'b0;
        allow_d = TABLED_M;
        resv_d  = '0;
        case (op)
            OP_NOOP:  begin allow_d = AL_NOOP;  resv_d = RB_NOOP; end
            OP_DRAIN: begin allow_d = AL_DRAIN; resv_d = RB_DRAIN; end
            OP_MOVE:  begin allow_d = AL_MOVE; resv_d = RB_MOVE; wrmem_d = 1'b1; end
            OP_FILL:  begin allow_d = AL_FILL; resv_d = RB_MOVE; wrmem_d = 1'b1; end
            OP_CMP:   begin allow_d = AL_CMP;   resv_d = RB_CMP; end
            OP_CMPP:  begin allow_d = AL_CMPP;  resv_d = RB_CMP; end
            OP_CRDEL: begin allow_d = AL_CRDEL; resv_d = RB_CRDEL; wrmem_d = 1'b1; end
            OP_APDEL: begin allow_d = AL_MOVE; resv_d = RB_APDEL; wrmem_d = 1'b1; end
            OP_DUAL:  begin allow_d = AL_DUAL; resv_d = RB_DUAL; wrmem_d = 1'b1; end
            OP_CRC:   begin allow_d = AL_CRC;   resv_d = RB_CRC; end
            OP_CPCRC: begin allow_d = AL_DUAL; resv_d = RB_APDEL; wrmem_d = 1'b1; end
            OP_DIFC:  begin allow_d = AL_DIFC;  resv_d = RB_DIFC; end
            OP_DIFI:  begin allow_d = AL_MOVE; resv_d = RB_DIFI; wrmem_d = 1'b1; end
            OP_DIFS:  begin allow_d = AL_MOVE; resv_d = RB_DIFS; wrmem_d = 1'b1; end
            OP_DIFU:  begin allow_d = AL_MOVE; resv_d = RB_DIFU; wrmem_d = 1'b1; end
            OP_FLUSH: begin allow_d = AL_FILL;  resv_d = RB_FLUSH; end
            OP_BATCH: begin allow_d = AL_BATCH; resv_d = RB_BATCH; end
            // Unknown codes are caught by the opcode check, not here
            default:  known_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            allow_q  <= '0;
            resv_q   <= '0;
            known_q  <= 1'b0;
            wrmem_q  <= 1'b0;
            flush_q  <= 1'b0;
            drain_q  <= 1'b0;
            needcr_q <= 1'b0;
        end else begin
            allow_q  <= allow_d;
            resv_q   <= resv_d;
            known_q  <= known_d;
            wrmem_q  <= wrmem_d;
            flush_q  <= (op == OP_FLUSH);
            drain_q  <= (op == OP_DRAIN);
            needcr_q <= (op == OP_CMP) || (op == OP_CMPP) || (op == OP_CRDEL) ||
                        (op == OP_CRC) || (op == OP_CPCRC) || (op == OP_DIFC);
        end
    end
endmodule : drc_op_table

// ==== hw/drc_byte_scan.sv ====
// Per-byte nonzero detector over the descriptor
`timescale 1ns/100ps
module drc_byte_scan
    import drc_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Descriptor in, nonzero bytes out
    input  wire logic [DESC_W-1:0] desc,
    output logic      [63:0]       nz_q
);
    genvar b;
    generate
        for (b = 0; b < 64; b++) begin : g_byte
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    nz_q[b] <= 1'b0;
                end else begin
                    nz_q[b] <= |desc[8*b +: 8];
                end
            end
        end
    endgenerate
endmodule : drc_byte_scan

// ==== hw/drc_checker.sv ====
// Descriptor reserved-field checker, two-cycle pipeline
`timescale 1ns/100ps
module drc_checker
    import drc_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Descriptor in
    input  wire logic              in_valid,
    input  wire logic [DESC_W-1:0] in_desc,
    input  wire logic              in_batch,
    // Configuration and capability
    input  wire logic              cfg_umi_en,
    input  wire logic              cfg_wq_pasid_en,
    input  wire logic              cfg_wq_bof_en,
    input  wire logic              cfg_tph_st_mode,
    input  wire logic              cap_dst_readback,
    input  wire logic              cap_cc_memory,
    input  wire logic              cap_cc_flush,
    input  wire logic              cap_drain_readback,
    // Result
    output logic                   out_valid,
    output logic                   out_pass,
    output logic                   out_flag_fail,
    output logic                   out_field_fail,
    output logic                   out_req_fail,
    output logic                   out_op_known,
    output logic      [23:0]       out_inv_flags,
    output logic                   out_to_swerr,
    output logic                   out_to_record
);
    // Stage one copies
    logic        s1_valid_q;
    logic [23:0] s1_flags_q;
    logic        s1_priv_q;
    logic        s1_batch_q;
    logic [7:0]  s1_cfg_q;
    logic [23:0] allow_w;
    logic [63:0] resv_w;
    logic [63:0] nz_w;
    logic        known_w;
    logic        wrmem_w;
    logic        flush_w;
    logic        drain_w;
    logic        needcr_w;

    // Stage two evaluation
    logic [23:0] bad_d;
    logic [63:0] fld_d;
    logic        crav;
    logic        rcr;
    logic        rci;
    logic        field_fail_d;
    logic        req_fail_d;
    logic        fail_d;

    drc_op_table u_table (
        .clock    (clock),
        .rst      (rst),
        .op       (in_desc[OPC_LO +: 8]),
        .allow_q  (allow_w),
        .resv_q   (resv_w),
        .known_q  (known_w),
        .wrmem_q  (wrmem_w),
        .flush_q  (flush_w),
        .drain_q  (drain_w),
        .needcr_q (needcr_w)
    );

    drc_byte_scan u_scan (
        .clock (clock),
        .rst   (rst),
        .desc  (in_desc),
        .nz_q  (nz_w)
    );

    // Config is captured with the descriptor so one result sees one setting
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_valid_q <= 1'b0;
            s1_flags_q <= '0;
            s1_priv_q  <= 1'b0;
            s1_batch_q <= 1'b0;
            s1_cfg_q   <= '0;
        end else begin
            s1_valid_q <= in_valid;
            s1_flags_q <= in_desc[FLAGS_LO +: FLAGS_W];
            s1_priv_q  <= in_desc[PRIV_BIT];
            s1_batch_q <= in_batch;
            s1_cfg_q   <= {cap_drain_readback, cap_cc_flush, cap_cc_memory,
                           cap_dst_readback, cfg_tph_st_mode, cfg_wq_bof_en,
                           cfg_wq_pasid_en, cfg_umi_en};
        end
    end

    always_comb begin
        crav  = s1_flags_q[F_CRAV];
        rcr   = s1_flags_q[F_RCR];
        rci   = s1_flags_q[F_RCI];
        bad_d = '0;
        // Tabled flags not allowed by this op; untabled ones pass
        bad_d = bad_d | (s1_flags_q & TABLED_M & ~allow_w);
        bad_d[F_RSV6] = s1_flags_q[F_RSV6];
        // Only Drain gives meaning to the op-specific byte
        bad_d = bad_d | (s1_flags_q & OPSPEC_M & ~(drain_w ? DRAIN_OPSPEC : 24'h000000));
        if (!s1_cfg_q[0] && s1_cfg_q[1] && !s1_priv_q) begin
            bad_d[F_RCI] = rci;
        end
        if (!s1_batch_q) begin
            bad_d[F_FENCE] = s1_flags_q[F_FENCE];
        end
        if (!s1_cfg_q[2]) begin
            bad_d[F_BOF] = s1_flags_q[F_BOF];
        end
        if (!s1_cfg_q[4]) begin
            bad_d[F_DRB] = s1_flags_q[F_DRB];
        end
        if (!s1_cfg_q[3]) begin
            bad_d[F_DSTST] = s1_flags_q[F_DSTST];
        end
        if (drain_w && !s1_flags_q[F_RB1V]) begin
            bad_d[F_A1TC] = s1_flags_q[F_A1TC];
        end
        if (drain_w && !s1_flags_q[F_RB2V]) begin
            bad_d[F_A2TC] = s1_flags_q[F_A2TC];
        end
        if (!crav) begin
            bad_d[F_RCR]  = rcr;
            bad_d[F_CRTC] = s1_flags_q[F_CRTC];
        end
        if (!crav || !s1_cfg_q[3]) begin
            bad_d[F_CRST] = s1_flags_q[F_CRST];
        end
        if ((wrmem_w && !s1_cfg_q[5]) || (flush_w && !s1_cfg_q[6])) begin
            bad_d[F_CC] = s1_flags_q[F_CC];
        end
        if (drain_w && !s1_cfg_q[7]) begin
            bad_d[F_RB1V] = s1_flags_q[F_RB1V];
            bad_d[F_RB2V] = s1_flags_q[F_RB2V];
        end
        // Unknown opcode: the opcode check owns it, report no flag faults
        if (!known_w) begin
            bad_d = '0;
        end
        fld_d = resv_w;
        if (!crav) begin
            fld_d[CRA_HI:CRA_LO] = '1;
        end
        if (!rci) begin
            fld_d[IH_HI:IH_LO] = '1;
        end
        if (!known_w) begin
            fld_d = '0;
        end
        field_fail_d = |(fld_d & nz_w);
        req_fail_d   = (drain_w && !rcr && !rci) || (needcr_w && !(crav && rcr));
        fail_d       = (|bad_d) || field_fail_d || req_fail_d;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_valid      <= 1'b0;
            out_pass       <= 1'b0;
            out_flag_fail  <= 1'b0;
            out_field_fail <= 1'b0;
            out_req_fail   <= 1'b0;
            out_op_known   <= 1'b0;
            out_inv_flags  <= '0;
        end else begin
            out_valid      <= s1_valid_q;
            out_pass       <= s1_valid_q && !fail_d;
            out_flag_fail  <= s1_valid_q && (|bad_d);
            out_field_fail <= s1_valid_q && field_fail_d;
            out_req_fail   <= s1_valid_q && req_fail_d;
            out_op_known   <= s1_valid_q && known_w;
            out_inv_flags  <= s1_valid_q ? bad_d : 24'h000000;
        end
    end

    // Error routing; a bad record address itself is another check's job
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_to_swerr  <= 1'b0;
            out_to_record <= 1'b0;
        end else begin
            out_to_swerr  <= s1_valid_q && fail_d && !crav;
            out_to_record <= s1_valid_q && fail_d && crav;
        end
    end

    // Checks on the pipeline
    a_bit6_flag: assert property (@(posedge clock) disable iff (rst)
        in_valid && in_desc[FLAGS_LO + F_RSV6] ##1 known_w
        |=> out_flag_fail && out_inv_flags[F_RSV6] && !out_pass)
        else $error("flag bit 6 not flagged");
    a_opspec_resv: assert property (@(posedge clock) disable iff (rst)
        in_valid && in_desc[FLAGS_LO + 20] ##1 known_w
        |=> out_inv_flags[20])
        else $error("op-specific flag not reserved");
    a_fence_direct: assert property (@(posedge clock) disable iff (rst)
        in_valid && !in_batch && in_desc[FLAGS_LO + F_FENCE] ##1 known_w
        |=> out_inv_flags[F_FENCE])
        else $error("direct fence not flagged");
    a_bof_cfg: assert property (@(posedge clock) disable iff (rst)
        in_valid && !cfg_wq_bof_en && in_desc[FLAGS_LO + F_BOF] ##1 known_w
        |=> out_inv_flags[F_BOF])
        else $error("block-on-fault not flagged");
    a_drain_req: assert property (@(posedge clock) disable iff (rst)
        in_valid && in_desc[OPC_LO +: 8] == OP_DRAIN &&
        !in_desc[FLAGS_LO + F_RCR] && !in_desc[FLAGS_LO + F_RCI]
        ##2 out_valid |-> out_req_fail && !out_pass)
        else $error("drain without completion not flagged");
    a_cmp_req: assert property (@(posedge clock) disable iff (rst)
        in_valid && in_desc[OPC_LO +: 8] == OP_CMP && !in_desc[FLAGS_LO + F_CRAV]
        |-> ##2 out_req_fail && out_to_swerr)
        else $error("compare without record not flagged");
    a_swerr_route: assert property (@(posedge clock) disable iff (rst)
        s1_valid_q && fail_d && !s1_flags_q[F_CRAV]
        |=> out_to_swerr && !out_to_record)
        else $error("failure not routed to error register");
    a_record_route: assert property (@(posedge clock) disable iff (rst)
        out_to_record |-> !out_pass && out_valid && !out_to_swerr)
        else $error("record routing inconsistent");
    a_pass_clean: assert property (@(posedge clock) disable iff (rst)
        out_pass |-> out_valid && out_inv_flags == 24'h000000 &&
        !out_field_fail && !out_req_fail)
        else $error("pass with faults");
    a_difc_byte41: assert property (@(posedge clock) disable iff (rst)
        in_valid && in_desc[OPC_LO +: 8] == OP_DIFC && |in_desc[8*41 +: 8]
        |-> ##2 out_field_fail)
        else $error("DIF check byte 41 not flagged");
    a_ihandle_resv: assert property (@(posedge clock) disable iff (rst)
        in_valid && in_desc[OPC_LO +: 8] == OP_MOVE && !in_desc[FLAGS_LO + F_RCI] &&
        |in_desc[8*IH_LO +: 8] |-> ##2 out_field_fail)
        else $error("interrupt handle not reserved");
    a_valid_lat: assert property (@(posedge clock) disable iff (rst)
        in_valid |-> ##2 out_valid)
        else $error("result latency not two cycles");

    c_pass: cover property (@(posedge clock) disable iff (rst) out_pass);
    c_swerr: cover property (@(posedge clock) disable iff (rst) out_to_swerr);
    c_record: cover property (@(posedge clock) disable iff (rst)
        out_to_record && out_flag_fail);
    c_back2back: cover property (@(posedge clock) disable iff (rst)
        out_valid ##1 out_valid);
endmodule : drc_checker

// ==== sim/drc_front_model.sv ====
// Submission front end model feeding descriptors to the checker
`timescale 1ns/100ps
module drc_front_model
    import drc_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Request from bench
    input  wire logic              req,
    input  wire logic [DESC_W-1:0] req_desc,
    input  wire logic              req_batch,
    // Toward checker
    output logic                   in_valid,
    output logic      [DESC_W-1:0] in_desc,
    output logic                   in_batch
);
    initial begin
        in_valid = 1'b0;
        in_desc  = '0;
        in_batch = 1'b0;
    end

    always @(posedge clock) begin
        in_valid <= req;
        // Idle bus inverts its last value each cycle, so every second idle cycle shows a stale copy
        in_desc  <= req ? req_desc : ~in_desc;
        in_batch <= req ? req_batch : ~in_batch;
    end
endmodule : drc_front_model

// ==== sim/descriptor_reserved_field_checker_bench.sv ====
// Bench for the descriptor reserved-field checker
`timescale 1ns/100ps
module descriptor_reserved_field_checker_bench
    import drc_pkg::*;
;
    logic              clock = 1'b0;
    logic              rst   = 1'b1;
    logic              req   = 1'b0;
    logic              req_batch = 1'b0;
    logic [DESC_W-1:0] req_desc  = '0;
    logic              in_valid, in_batch;
    logic [DESC_W-1:0] in_desc;
    logic [7:0]        cf = 8'hbf;
    logic              out_valid, out_pass, out_flag_fail, out_field_fail;
    logic              out_req_fail, out_op_known, out_to_swerr, out_to_record;
    logic [23:0]       out_inv_flags;
    int                n_fail = 0;
    int                comparisons = 0;
    localparam logic [23:0] CR = 24'h00000c;

    always #2 clock = ~clock;

    drc_front_model fm_u (.clock(clock), .req(req), .req_desc(req_desc),
        .req_batch(req_batch), .in_valid(in_valid), .in_desc(in_desc), .in_batch(in_batch));

    drc_checker dut_u (.clock(clock), .rst(rst), .in_valid(in_valid), .in_desc(in_desc),
        .in_batch(in_batch), .cfg_umi_en(cf[7]), .cfg_wq_pasid_en(cf[6]),
        .cfg_wq_bof_en(cf[5]), .cfg_tph_st_mode(cf[4]), .cap_dst_readback(cf[3]),
        .cap_cc_memory(cf[2]), .cap_cc_flush(cf[1]), .cap_drain_readback(cf[0]),
        .out_valid(out_valid), .out_pass(out_pass), .out_flag_fail(out_flag_fail),
        .out_field_fail(out_field_fail), .out_req_fail(out_req_fail),
        .out_op_known(out_op_known), .out_inv_flags(out_inv_flags),
        .out_to_swerr(out_to_swerr), .out_to_record(out_to_record));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [23:0] b(input int k);
        return 24'h000001 << k;
    endfunction : b

    // One descriptor through, all outputs judged
    task automatic go(input logic [7:0] op, input logic [23:0] fl, input int bn,
        input logic [7:0] v, input logic bt, input logic [7:0] c, input logic [23:0] ei,
        input logic ef, input logic er);
        logic [DESC_W-1:0] d;
        logic              fl_bad;
        int                i;
        d = '0;
        d[63:56] = op;
        d[55:32] = fl;
        if (bn > 0) d[8*bn +: 8] = v;
        fl_bad = (ei != 24'h0) || ef || er;
        @(posedge clock);
        req <= 1'b1;
        req_desc <= d;
        req_batch <= bt;
        cf <= c;
        @(posedge clock);
        req <= 1'b0;
        i = 0;
        do begin
            @(posedge clock);
            #1;
            i++;
        end while (out_valid !== 1'b1 && i < 8);
        if (out_valid !== 1'b1) begin
            chk("out_valid", 24'(out_valid), 24'h1);
            give_verdict();
        end
        chk("inv_flags", out_inv_flags, ei);
        chk("flag_fail", 24'(out_flag_fail), 24'(ei != 24'h0));
        chk("field_fail", 24'(out_field_fail), 24'(ef));
        chk("req_fail", 24'(out_req_fail), 24'(er));
        chk("pass", 24'(out_pass), 24'(!fl_bad));
        chk("to_record", 24'(out_to_record), 24'(fl_bad && fl[F_CRAV]));
        chk("to_swerr", 24'(out_to_swerr), 24'(fl_bad && !fl[F_CRAV]));
        // Opcode 30 is the one unused code driven here
        chk("op_known", 24'(out_op_known), 24'(op != 8'h30));
        @(posedge clock);
        #1;
        chk("pulse", 24'(out_valid), 24'h0);
    endtask : go

    task automatic t_always();
        go(OP_MOVE, CR | b(6), 0, 0, 0, 8'hbf, b(6), 0, 0);
        go(OP_MOVE, b(16), 0, 0, 0, 8'hbf, b(16), 0, 0);
        go(OP_NOOP, CR | b(F_RCI) | b(F_CRTC), 0, 0, 0, 8'hbf, 0, 0, 0);
        go(OP_NOOP, CR | b(F_BOF), 0, 0, 0, 8'hbf, b(F_BOF), 0, 0);
        go(8'h30, CR | b(6), 0, 0, 0, 8'hbf, 0, 0, 0);
        $display("test always done");
    endtask : t_always

    // Reserved bytes probed at the edges of some ranges of OP_DIFC, OP_DIFI, OP_DIFS, OP_CRDEL and OP_CRC
    logic [7:0] bop[19] = '{8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h13, 8'h13, 8'h13, 8'h13,
        8'h14, 8'h14, 8'h14, 8'h07, 8'h07, 8'h07, 8'h10, 8'h10, 8'h10, 8'h10};
    int bbn[19] = '{24, 40, 41, 42, 63, 40, 41, 55, 56, 41, 24, 47, 52, 56, 57, 31, 40, 44, 63};
    logic bex[19] = '{1, 0, 1, 0, 1, 1, 0, 1, 0, 1, 0, 1, 1, 0, 1, 1, 0, 1, 1};

    task automatic t_bytes();
        for (int k = 0; k < 19; k++) begin
            go(bop[k], CR, bbn[k], 8'h5a, 0, 8'hbf, 0, bex[k], 0);
        end
        $display("test bytes done");
    endtask : t_bytes

    task automatic t_cond();
        go(OP_MOVE, CR | b(F_RCI), 0, 0, 0, 8'h7f, b(F_RCI), 0, 0);
        go(OP_MOVE, CR | b(F_RCI), 3, 8'h80, 0, 8'h7f, 0, 0, 0);
        go(OP_MOVE, CR, 36, 8'h01, 0, 8'hbf, 0, 1, 0);
        go(OP_MOVE, CR | b(F_FENCE), 0, 0, 0, 8'hbf, b(F_FENCE), 0, 0);
        go(OP_MOVE, CR | b(F_FENCE), 0, 0, 1, 8'hbf, 0, 0, 0);
        go(OP_MOVE, CR | b(F_BOF), 0, 0, 0, 8'h9f, b(F_BOF), 0, 0);
        go(OP_MOVE, CR | b(F_DRB), 0, 0, 0, 8'hb7, b(F_DRB), 0, 0);
        go(OP_MOVE, CR | b(F_DSTST), 0, 0, 0, 8'haf, b(F_DSTST), 0, 0);
        go(OP_MOVE, CR | b(F_CRST), 0, 0, 0, 8'haf, b(F_CRST), 0, 0);
        go(OP_MOVE, b(F_CRST), 0, 0, 0, 8'hbf, b(F_CRST), 0, 0);
        go(OP_MOVE, b(F_RCR), 0, 0, 0, 8'hbf, b(F_RCR), 0, 0);
        go(OP_MOVE, b(F_CRTC), 0, 0, 0, 8'hbf, b(F_CRTC), 0, 0);
        go(OP_MOVE, 24'h0, 8, 8'h40, 0, 8'hbf, 0, 1, 0);
        go(OP_MOVE, CR | b(F_CC), 0, 0, 0, 8'hbb, b(F_CC), 0, 0);
        go(OP_FLUSH, CR | b(F_CC), 0, 0, 0, 8'hbd, b(F_CC), 0, 0);
        $display("test conditional done");
    endtask : t_cond

    task automatic t_req();
        go(OP_DRAIN, b(F_RCI) | b(F_RB1V) | b(F_A1TC), 0, 0, 0, 8'hbf, 0, 0, 0);
        go(OP_DRAIN, b(F_RCI) | b(F_A1TC), 0, 0, 0, 8'hbf, b(F_A1TC), 0, 0);
        go(OP_DRAIN, b(F_RCI) | b(F_RB2V), 0, 0, 0, 8'hbe, b(F_RB2V), 0, 0);
        go(OP_DRAIN, 24'h0, 0, 0, 0, 8'hbf, 0, 0, 1);
        go(OP_CMP, b(F_CRAV), 0, 0, 0, 8'hbf, 0, 0, 1);
        go(OP_CRC, CR, 0, 0, 0, 8'hbf, 0, 0, 0);
        $display("test required done");
    endtask : t_req

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_always();
        t_bytes();
        t_cond();
        t_req();
        give_verdict();
    end
endmodule : descriptor_reserved_field_checker_bench
